/* core/asirr_pkg.sv */
// Package for the converter status, interrupt and result register block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package asirr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CHAN_STATE   = 8'h18;
    localparam logic [7:0] OFF_STATUS       = 8'h1C;
    localparam logic [7:0] OFF_LATEST       = 8'h20;
    localparam logic [7:0] OFF_IRQ_SET      = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLR      = 8'h28;
    localparam logic [7:0] OFF_IRQ_VIEW     = 8'h2C;
    localparam logic [7:0] OFF_RESULT0      = 8'h30;
    localparam logic [7:0] OFF_RESULT7      = 8'h4C;
    localparam logic [7:0] OFF_CHAN_ENABLE  = 8'h10;
    localparam logic [7:0] OFF_CHAN_DISABLE = 8'h14;
    localparam logic [7:0] OFF_MODE         = 8'h04;
    // Receive counters sit in the reserved window, clear of the mode register
    localparam logic [7:0] OFF_RX_COUNTER   = 8'hF4;
    localparam logic [7:0] OFF_RX_NEXT      = 8'hF8;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_DONE      = 0;
    localparam int POS_OVERRUN   = 8;
    localparam int POS_READY     = 16;
    localparam int POS_GEN_OVR   = 17;
    localparam int POS_RX_END    = 18;
    localparam int POS_RX_FULL   = 19;
    localparam int POS_REDUCED_RES = 4;
    localparam int STATUS_BITS   = 20;
    localparam int RESULT_BITS   = 10;
    localparam int REDUCED_BITS  = 8;
    localparam int COUNT_BITS    = 16;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CHAN_STATE = 8'h00;
    localparam logic [19:0] RST_MASK       = 20'h00000;
    localparam logic [9:0]  RST_RESULT     = 10'h000;
    localparam logic [15:0] RST_COUNT      = 16'h0000;

    // Conversion completion reported by the sequencer
    typedef struct packed {
        logic       done;
        logic [2:0] chan;
        logic [9:0] value;
    } asirr_conv_t;
endpackage : asirr_pkg

/* core/asirr_regs.sv */
// Status, interrupt and result registers of an eight-channel converter.
// Assumes a sequencer on pclk pulsing conv.done per finished conversion,
// and a DMA engine on pclk pulsing dma_take to consume one result.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Channel state shows one enable bit per channel
// [RQ2] Done flag reads 1 only if channel enabled
// [RQ3] Channel overrun sticky until status read
// [RQ4] Ready flag set on result, cleared reading latest
// [RQ5] General overrun sticky until status read
// [RQ6] Rx end set at zero, cleared on counter write
// [RQ7] Rx full while both counters are zero
// [RQ8] Latest result loaded on every conversion end
// [RQ9] Channel result loaded only when channel enabled
// [RQ10] Enable-set write sets mask bits written one
// [RQ11] Enable-clear write clears mask bits written one
// [RQ12] Mask view reads current enabled sources
// [RQ13] Mask bits align with status flag positions
// [RQ14] Disable mid-conversion leaves channel data undefined
// [RQ15] Low resolution selects eight significant bits
// [RQ16] Interrupt high while flag and mask both set
// [RQ17] Result read clears done; repeat done overruns
module asirr_regs #(
    parameter int NCHAN = 8
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire asirr_pkg::asirr_conv_t conv,
    input  wire logic                 dma_take,
    output logic      [9:0]           dma_data,
    output logic      [NCHAN-1:0]     chan_active,
    output logic                      reduced_resolution_select,
    output logic                      irq
);
    initial begin
        if (NCHAN != 8) $error("asirr_regs serves exactly eight channels");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;

    function automatic logic is_result(input logic [7:0] a);
        return (a >= asirr_pkg::OFF_RESULT0) && (a <= asirr_pkg::OFF_RESULT7);
    endfunction : is_result

    function automatic logic known_addr(input logic [7:0] a);
        return is_result(a) || a == asirr_pkg::OFF_CHAN_STATE
            || a == asirr_pkg::OFF_STATUS || a == asirr_pkg::OFF_LATEST
            || a == asirr_pkg::OFF_IRQ_SET || a == asirr_pkg::OFF_IRQ_CLR
            || a == asirr_pkg::OFF_IRQ_VIEW || a == asirr_pkg::OFF_CHAN_ENABLE
            || a == asirr_pkg::OFF_CHAN_DISABLE || a == asirr_pkg::OFF_MODE
            || a == asirr_pkg::OFF_RX_COUNTER || a == asirr_pkg::OFF_RX_NEXT;
    endfunction : known_addr

    assign pslverr = psel && penable && !known_addr(paddr);

    logic [2:0] rd_chan;
    assign rd_chan = 3'((paddr - asirr_pkg::OFF_RESULT0) >> 2);

    logic rd_status;
    logic rd_latest;
    logic rd_result;
    assign rd_status = rd_en && paddr == asirr_pkg::OFF_STATUS;
    assign rd_latest = (rd_en && paddr == asirr_pkg::OFF_LATEST) || dma_take;
    assign rd_result = rd_en && is_result(paddr);

    // ------------------------------------------------------------
    // Channel enables and mode
    // ------------------------------------------------------------
    logic [7:0] chan_active_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_active_bit <= asirr_pkg::RST_CHAN_STATE;
        end else if (wr_en && paddr == asirr_pkg::OFF_CHAN_ENABLE) begin
            chan_active_bit <= chan_active_bit | pwdata[7:0];
        end else if (wr_en && paddr == asirr_pkg::OFF_CHAN_DISABLE) begin
            // Disabling mid-conversion leaves that channel's data undefined [RQ14]
            chan_active_bit <= chan_active_bit & ~pwdata[7:0];
        end
    end
    assign chan_active = chan_active_bit; // [RQ1]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reduced_resolution_select <= 1'b0;
        end else if (wr_en && paddr == asirr_pkg::OFF_MODE) begin
            reduced_resolution_select <= pwdata[asirr_pkg::POS_REDUCED_RES];
        end
    end

    // 8-bit mode keeps only the low eight bits significant [RQ15]
    logic [9:0] conv_value;
    assign conv_value = reduced_resolution_select ? {2'b00, conv.value[7:0]} : conv.value;

    logic chan_on;
    assign chan_on = chan_active_bit[conv.chan];

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    logic [9:0] latest_value;
    logic [9:0] per_channel_result [8];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latest_value <= asirr_pkg::RST_RESULT;
        end else if (conv.done) begin
            latest_value <= conv_value; // [RQ8]
        end
    end
    assign dma_data = latest_value;

    generate
        for (genvar c = 0; c < 8; c++) begin : g_res
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    per_channel_result[c] <= asirr_pkg::RST_RESULT;
                end else if (conv.done && conv.chan == 3'(c) && chan_active_bit[c]) begin
                    per_channel_result[c] <= conv_value; // [RQ9]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic [7:0] done_raw;
    logic [7:0] conversion_done_flag;
    logic [7:0] chan_overrun_flag;
    logic       result_ready_flag;
    logic       general_overrun_flag;
    logic       rx_buffer_end_flag;
    logic       rx_buffers_full_flag;
    logic [15:0] rx_counter;
    logic [15:0] rx_next_counter;

    generate
        for (genvar c = 0; c < 8; c++) begin : g_flag
            logic hit;
            assign hit = conv.done && conv.chan == 3'(c) && chan_active_bit[c];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    done_raw[c] <= 1'b0;
                end else if (hit) begin
                    done_raw[c] <= 1'b1; // Set wins over a read in the same cycle
                end else if (rd_result && rd_chan == 3'(c)) begin
                    done_raw[c] <= 1'b0; // [RQ17]
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chan_overrun_flag[c] <= 1'b0;
                end else if (hit && done_raw[c]) begin
                    chan_overrun_flag[c] <= 1'b1; // [RQ3] [RQ17]
                end else if (rd_status) begin
                    chan_overrun_flag[c] <= 1'b0; // [RQ3]
                end
            end
        end
    endgenerate
    assign conversion_done_flag = done_raw & chan_active_bit; // [RQ2]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ready_flag <= 1'b0;
        end else if (conv.done) begin
            result_ready_flag <= 1'b1; // [RQ4]
        end else if (rd_latest) begin
            result_ready_flag <= 1'b0; // [RQ4]
        end
    end

    // A fresh result while the previous one is unread is a general overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_overrun_flag <= 1'b0;
        end else if (conv.done && result_ready_flag && !rd_latest) begin
            general_overrun_flag <= 1'b1; // [RQ5]
        end else if (rd_status) begin
            general_overrun_flag <= 1'b0; // [RQ5]
        end
    end

    // ------------------------------------------------------------
    // DMA receive counters
    // ------------------------------------------------------------
    logic cnt_wr;
    logic nxt_wr;
    logic dma_step;
    logic rx_hit_zero;
    assign cnt_wr   = wr_en && paddr == asirr_pkg::OFF_RX_COUNTER;
    assign nxt_wr   = wr_en && paddr == asirr_pkg::OFF_RX_NEXT;
    assign dma_step = dma_take && rx_counter != asirr_pkg::RST_COUNT;
    assign rx_hit_zero = dma_step && rx_counter == 16'h0001
                       && rx_next_counter == asirr_pkg::RST_COUNT;

    // When the current count ends, the next count is loaded in its place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_counter      <= asirr_pkg::RST_COUNT;
            rx_next_counter <= asirr_pkg::RST_COUNT;
        end else begin
            if (cnt_wr) begin
                rx_counter <= pwdata[15:0];
            end else if (dma_step && rx_counter == 16'h0001) begin
                rx_counter <= rx_next_counter;
            end else if (dma_step) begin
                rx_counter <= rx_counter - 16'h0001;
            end
            if (nxt_wr) begin
                rx_next_counter <= pwdata[15:0];
            end else if (!cnt_wr && dma_step && rx_counter == 16'h0001) begin
                rx_next_counter <= asirr_pkg::RST_COUNT;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_end_flag <= 1'b1;
        end else if (rx_hit_zero && !cnt_wr) begin
            // Reaching zero wins over a next-counter write in the same cycle
            rx_buffer_end_flag <= 1'b1; // [RQ6]
        end else if (cnt_wr || nxt_wr) begin
            rx_buffer_end_flag <= 1'b0; // [RQ6]
        end
    end
    assign rx_buffers_full_flag = rx_counter == asirr_pkg::RST_COUNT
                                && rx_next_counter == asirr_pkg::RST_COUNT; // [RQ7]

    // ------------------------------------------------------------
    // Interrupt mask
    // ------------------------------------------------------------
    logic [19:0] status_word;
    logic [19:0] irq_mask;
    assign status_word = {rx_buffers_full_flag, rx_buffer_end_flag, general_overrun_flag,
                          result_ready_flag, chan_overrun_flag, conversion_done_flag}; // [RQ13]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= asirr_pkg::RST_MASK;
        end else if (wr_en && paddr == asirr_pkg::OFF_IRQ_SET) begin
            irq_mask <= irq_mask | pwdata[19:0]; // [RQ10]
        end else if (wr_en && paddr == asirr_pkg::OFF_IRQ_CLR) begin
            irq_mask <= irq_mask & ~pwdata[19:0]; // [RQ11]
        end
    end
    assign irq = |(status_word & irq_mask); // [RQ16]

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        prdata = 32'h00000000;
        if (rd_en) begin
            case (paddr)
                asirr_pkg::OFF_CHAN_STATE: prdata = {24'h000000, chan_active_bit};
                asirr_pkg::OFF_STATUS:     prdata = {12'h000, status_word};
                asirr_pkg::OFF_LATEST:     prdata = {22'h000000, latest_value};
                asirr_pkg::OFF_IRQ_VIEW:   prdata = {12'h000, irq_mask}; // [RQ12]
                asirr_pkg::OFF_MODE:       prdata = 32'(reduced_resolution_select)
                                                    << asirr_pkg::POS_REDUCED_RES;
                asirr_pkg::OFF_RX_COUNTER: prdata = {16'h0000, rx_counter};
                asirr_pkg::OFF_RX_NEXT:    prdata = {16'h0000, rx_next_counter};
                default: begin
                    if (is_result(paddr)) begin
                        prdata = {22'h000000, per_channel_result[rd_chan]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_done_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
        (conversion_done_flag & ~chan_active_bit) == 8'h00)
        else $error("done flag set on disabled channel");
    chk_latest_loads: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
        conv.done |=> latest_value == $past(conv_value))
        else $error("latest result not loaded");
    chk_ready_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
        (rd_latest && !conv.done) |=> !result_ready_flag)
        else $error("ready flag not cleared by read");
    chk_ovr_status_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
        (rd_status && !conv.done) |=> chan_overrun_flag == 8'h00)
        else $error("overrun not cleared by status read");
    chk_gen_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
        (rd_status && !conv.done) |=> !general_overrun_flag)
        else $error("general overrun not cleared");
    chk_rx_end_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        (cnt_wr || (nxt_wr && !rx_hit_zero)) |=> !rx_buffer_end_flag)
        else $error("rx end not cleared by counter write");
    chk_rx_full: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
        rx_buffers_full_flag == (rx_counter == 16'h0000 && rx_next_counter == 16'h0000))
        else $error("rx full mismatch");
    chk_mask_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
        (wr_en && paddr == asirr_pkg::OFF_IRQ_SET) |=> (irq_mask & $past(pwdata[19:0]))
        == $past(pwdata[19:0]))
        else $error("mask set failed");
    chk_mask_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
        (wr_en && paddr == asirr_pkg::OFF_IRQ_CLR) |=> (irq_mask & $past(pwdata[19:0]))
        == 20'h00000)
        else $error("mask clear failed");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        irq == ((status_word & irq_mask) != 20'h00000))
        else $error("irq level wrong");
    chk_repeat_overrun: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
        (conv.done && chan_on && done_raw[conv.chan]) |=> chan_overrun_flag[$past(conv.chan)])
        else $error("repeat completion without overrun");
    chk_chan_enable: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
        (wr_en && paddr == asirr_pkg::OFF_CHAN_ENABLE)
        |=> (chan_active_bit & $past(pwdata[7:0])) == $past(pwdata[7:0]))
        else $error("channel enable failed");
    chk_chan_disable: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
        (wr_en && paddr == asirr_pkg::OFF_CHAN_DISABLE)
        |=> (chan_active_bit & $past(pwdata[7:0])) == 8'h00)
        else $error("channel disable failed");
    chk_result_gated: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        (conv.done && !chan_on)
        |=> per_channel_result[$past(conv.chan)] == $past(per_channel_result[conv.chan]))
        else $error("disabled channel result changed");
    chk_result_loads: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        (conv.done && chan_on) |=> per_channel_result[$past(conv.chan)] == $past(conv_value))
        else $error("channel result not loaded");
    chk_ready_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
        conv.done |=> result_ready_flag)
        else $error("ready flag not set");
    chk_gen_ovr_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
        (conv.done && result_ready_flag && !rd_latest) |=> general_overrun_flag)
        else $error("general overrun not set");
    chk_rx_end_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        (rx_hit_zero && !cnt_wr) |=> rx_buffer_end_flag)
        else $error("rx end not set at zero");
    chk_reduced_bits: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
        reduced_resolution_select |-> conv_value[9:8] == 2'b00)
        else $error("reduced result too wide");
    chk_done_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
        (rd_result && !(conv.done && chan_on && conv.chan == rd_chan))
        |=> !done_raw[$past(rd_chan)])
        else $error("result read left done flag");
    chk_rx_count_down: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        (dma_step && rx_counter != 16'h0001 && !cnt_wr)
        |=> rx_counter == $past(rx_counter) - 16'h0001)
        else $error("rx counter did not step");
    chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        (irq_mask == 20'h00000) |-> !irq)
        else $error("irq with all sources masked");
    chk_full_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
        (cnt_wr && pwdata[15:0] != 16'h0000) |=> !rx_buffers_full_flag)
        else $error("rx full with nonzero count");
    chk_latest_holds: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
        !conv.done |=> $stable(latest_value))
        else $error("latest result changed without completion");
    chk_done_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
        (conv.done && chan_on && !(wr_en && paddr == asirr_pkg::OFF_CHAN_DISABLE))
        |=> conversion_done_flag[$past(conv.chan)])
        else $error("done flag not set");
endmodule : asirr_regs

/* verif/asirr_conv_model.sv */
// Partner model: conversion sequencer and DMA engine on the far side.
// Assumes the bench calls its tasks from one process, right after a pclk edge.
`timescale 1ns/1ps
module asirr_conv_model (
    input  wire logic              pclk,
    output asirr_pkg::asirr_conv_t conv,
    output logic                   dma_take
);
    initial begin
        conv     = '0;
        dma_take = 1'b0;
    end

    // ------------------------------------------------------------
    // Completion and DMA pulses
    // ------------------------------------------------------------
    // Idle value is scrambled so a stale result cannot pass for a fresh one
    task automatic convert(input logic [2:0] chan, input logic [9:0] value);
        @(posedge pclk);
        conv <= '{done: 1'b1, chan: chan, value: value};
        @(posedge pclk);
        conv <= '{done: 1'b0, chan: ~chan, value: ~value};
    endtask : convert

    task automatic take();
        @(posedge pclk);
        dma_take <= 1'b1;
        @(posedge pclk);
        dma_take <= 1'b0;
    endtask : take
endmodule : asirr_conv_model

/* verif/tb.sv */
// Self-checking bench for the converter status, interrupt and result block.
// Assumes the APB slave answers with pready; the partner model feeds conversions.
`timescale 1ns/1ps
module tb;
    logic                   pclk;
    logic                   presetn;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [7:0]             paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    asirr_pkg::asirr_conv_t conv;
    logic                   dma_take;
    logic [9:0]             dma_data;
    logic [7:0]             chan_active;
    logic                   reduced_res;
    logic                   irq;
    logic [31:0]            r_data;
    logic                   r_err;
    int                     n_mismatch;
    int                     checks_done;
    int                     cycles;

    asirr_regs #(.NCHAN(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv(conv), .dma_take(dma_take),
        .dma_data(dma_data), .chan_active(chan_active),
        .reduced_resolution_select(reduced_res), .irq(irq)
    );

    asirr_conv_model model (.pclk(pclk), .conv(conv), .dma_take(dma_take));

    // ------------------------------------------------------------
    // Clock, timeout and report
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Whole run needs well under 400 cycles; this cuts a hung handshake
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // APB master and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch = n_mismatch + 1;
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r_data = prdata;
        r_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(r_data, exp);
    endtask : rd

    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask : chk_irq

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(asirr_pkg::OFF_STATUS, 32'h000C_0000);
        rd(asirr_pkg::OFF_CHAN_STATE, 32'h0000_0000);
        rd(asirr_pkg::OFF_IRQ_VIEW, 32'h0000_0000);
        rd(asirr_pkg::OFF_LATEST, 32'h0000_0000);
        rd(8'h50, 32'h0000_0000);
        chk({31'h0000_0000, r_err}, 32'h0000_0001);
        // Enable then disable overlapping channel sets
        wr(asirr_pkg::OFF_CHAN_ENABLE, 32'h0000_00A5);
        rd(asirr_pkg::OFF_CHAN_STATE, 32'h0000_00A5);
        wr(asirr_pkg::OFF_CHAN_DISABLE, 32'h0000_0005);
        rd(asirr_pkg::OFF_CHAN_STATE, 32'h0000_00A0);
        chk({24'h00_0000, chan_active}, 32'h0000_00A0);
        // Disabled channel updates only the latest result
        model.convert(3'd1, 10'h155);
        rd(asirr_pkg::OFF_STATUS, 32'h000D_0000);
        rd(asirr_pkg::OFF_RESULT0 + 8'h04, 32'h0000_0000);
        rd(asirr_pkg::OFF_LATEST, 32'h0000_0155);
        rd(asirr_pkg::OFF_STATUS, 32'h000C_0000);
        model.convert(3'd5, 10'h2AB);
        rd(asirr_pkg::OFF_STATUS, 32'h000D_0020);
        rd(asirr_pkg::OFF_RESULT0 + 8'h14, 32'h0000_02AB);
        rd(asirr_pkg::OFF_STATUS, 32'h000D_0000);
        rd(asirr_pkg::OFF_LATEST, 32'h0000_02AB);
        // Back-to-back completions on one channel overrun both flags
        model.convert(3'd7, 10'h3FF);
        model.convert(3'd7, 10'h1C3);
        rd(asirr_pkg::OFF_STATUS, 32'h000F_8080);
        rd(asirr_pkg::OFF_STATUS, 32'h000D_0080);
        // Interrupt mask set, clear and view
        chk_irq(1'b0);
        wr(asirr_pkg::OFF_IRQ_SET, 32'h0008_0080);
        rd(asirr_pkg::OFF_IRQ_VIEW, 32'h0008_0080);
        chk_irq(1'b1);
        wr(asirr_pkg::OFF_IRQ_CLR, 32'h0000_0080);
        rd(asirr_pkg::OFF_IRQ_VIEW, 32'h0008_0000);
        chk_irq(1'b1);
        wr(asirr_pkg::OFF_IRQ_CLR, 32'h0008_0000);
        chk_irq(1'b0);
        wr(asirr_pkg::OFF_IRQ_SET, 32'h0000_0080);
        chk_irq(1'b1);
        rd(asirr_pkg::OFF_RESULT7, 32'h0000_01C3);
        chk_irq(1'b0);
        // Receive counters and DMA consumption
        wr(asirr_pkg::OFF_RX_NEXT, 32'h0000_0002);
        rd(asirr_pkg::OFF_STATUS, 32'h0001_0000);
        chk({22'h00_0000, dma_data}, 32'h0000_01C3);
        model.take();
        rd(asirr_pkg::OFF_STATUS, 32'h0000_0000);
        // Count reloads from next, steps down, then ends at zero
        wr(asirr_pkg::OFF_RX_COUNTER, 32'h0000_0001);
        model.take();
        rd(asirr_pkg::OFF_RX_COUNTER, 32'h0000_0002);
        rd(asirr_pkg::OFF_RX_NEXT, 32'h0000_0000);
        model.take();
        model.take();
        rd(asirr_pkg::OFF_STATUS, 32'h000C_0000);
        // Reduced resolution keeps eight significant bits
        wr(asirr_pkg::OFF_MODE, 32'h0000_0010);
        @(negedge pclk);
        chk({31'h0000_0000, reduced_res}, 32'h0000_0001);
        model.convert(3'd5, 10'h3FF);
        rd(asirr_pkg::OFF_RESULT0 + 8'h14, 32'h0000_00FF);
        wrap_up();
    end
endmodule : tb
